// ==== rtl/abs_pkg.sv ====
`default_nettype none
// ============================================================
// Shared constants and carriers of the add/subtract unit
package abs_pkg;

    // ========================================================
    // Widths
    localparam int ABS_WORD_W  = 16;               // One storage word
    localparam int ABS_DATA_W  = 32;               // Double word and APB data
    localparam int ABS_ADDR_W  = 8;                // APB byte address
    localparam int ABS_CTRL_W  = 4;
    localparam int ABS_FLAG_W  = 3;
    localparam int ABS_IRQ_W   = 5;
    localparam int ABS_STRB_W  = 4;

    // ========================================================
    // Register byte offsets
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_CTRL     = 8'h00;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_SRC1_LO  = 8'h04;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_SRC1_HI  = 8'h08;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_SRC2_LO  = 8'h0C;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_SRC2_HI  = 8'h10;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_DEST_LO  = 8'h14;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_DEST_HI  = 8'h18;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_FLAGS    = 8'h1C;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_IRQ_STAT = 8'h20;
    localparam logic [ABS_ADDR_W-1:0] ABS_OFF_IRQ_MASK = 8'h24;

    // ========================================================
    // Field positions
    localparam int ABS_CTRL_SUB   = 0;             // 1 = subtract, 0 = add
    localparam int ABS_CTRL_WIDE  = 1;             // 1 = 32-bit form
    localparam int ABS_CTRL_PULSE = 2;             // 1 = run on enable rising edge only
    localparam int ABS_CTRL_CTR   = 3;             // Counter-operand request; refused unless WIDE is set
    localparam int ABS_IRQ_DONE   = 0;
    localparam int ABS_IRQ_CARRY  = 1;
    localparam int ABS_IRQ_BORROW = 2;
    localparam int ABS_IRQ_ZERO   = 3;
    localparam int ABS_IRQ_REFUSE = 4;

    // ========================================================
    // Reset values
    localparam logic [ABS_CTRL_W-1:0] ABS_CTRL_RST = 4'h0;
    localparam logic [ABS_WORD_W-1:0] ABS_WORD_RST = 16'h0000;
    localparam logic [ABS_IRQ_W-1:0]  ABS_IRQ_RST  = 5'h00;
    localparam logic [ABS_DATA_W-1:0] ABS_DATA_ZERO = 32'h0000_0000;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic                  sub;
        logic                  wide;
        logic [ABS_DATA_W-1:0] src1;
        logic [ABS_DATA_W-1:0] src2;
    } abs_req_t;

    typedef struct packed {
        logic                  zero;
        logic                  borrow;
        logic                  carry;
    } abs_flags_t;

    typedef struct packed {
        logic [ABS_DATA_W-1:0] dest;
        abs_flags_t            flags;
    } abs_res_t;

endpackage
`default_nettype wire

// ==== rtl/abs_arith.sv ====
`default_nettype none
// ============================================================
// Combinational add/subtract with wrap and status flags
module abs_arith (
    // Operation request
    input  wire abs_pkg::abs_req_t req_i,
    // Wrapped result and flags
    output var abs_pkg::abs_res_t  res_o
);
    import abs_pkg::*;

    logic [ABS_DATA_W:0] sum32_w;
    logic [ABS_DATA_W:0] dif32_w;
    logic [ABS_WORD_W:0] sum16_w;
    logic [ABS_WORD_W:0] dif16_w;

    // Extended sums keep the unsigned carry or borrow in the top bit
    assign sum32_w = {1'b0, req_i.src1} + {1'b0, req_i.src2};
    assign dif32_w = {1'b0, req_i.src1} - {1'b0, req_i.src2};
    assign sum16_w = {1'b0, req_i.src1[ABS_WORD_W-1:0]} + {1'b0, req_i.src2[ABS_WORD_W-1:0]};
    assign dif16_w = {1'b0, req_i.src1[ABS_WORD_W-1:0]} - {1'b0, req_i.src2[ABS_WORD_W-1:0]};

    // Select form, keep only the low bits of the true result
    always_comb begin
        res_o = '0;
        if (req_i.wide) begin
            res_o.dest         = req_i.sub ? dif32_w[ABS_DATA_W-1:0] : sum32_w[ABS_DATA_W-1:0];
            res_o.flags.carry  = sum32_w[ABS_DATA_W];
            res_o.flags.borrow = dif32_w[ABS_DATA_W];
        end else begin
            res_o.dest[ABS_WORD_W-1:0] = req_i.sub ? dif16_w[ABS_WORD_W-1:0]
                                                   : sum16_w[ABS_WORD_W-1:0];
            res_o.flags.carry  = sum16_w[ABS_WORD_W];
            res_o.flags.borrow = dif16_w[ABS_WORD_W];
        end
        res_o.flags.zero = (res_o.dest == ABS_DATA_ZERO);
    end

endmodule // abs_arith
`default_nettype wire

// ==== rtl/abs_trig.sv ====
`default_nettype none
// ============================================================
// Execution trigger: level or rising-edge of the enable
module abs_trig (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic enable_input_i,
    input  wire logic pulse_mode_i,
    // Trigger
    output logic      fire_o
);
    import abs_pkg::*;

    logic en_prev_r;

    // Previous enable level for edge detection
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= enable_input_i;
        end
    end

    // Level mode runs every active cycle, pulse mode once per rise
    assign fire_o = pulse_mode_i ? (enable_input_i & ~en_prev_r)
                                 : enable_input_i;

endmodule // abs_trig
`default_nettype wire

// ==== rtl/abs_top.sv ====
// Implementation choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
// ============================================================
// Add/subtract execution unit with APB register access
module abs_top #(
    parameter int ADDR_W = abs_pkg::ABS_ADDR_W
) (
    // Clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          rstn_i,
    // APB slave
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [ADDR_W-1:0]             paddr_i,
    input  wire logic [abs_pkg::ABS_DATA_W-1:0] pwdata_i,
    input  wire logic [abs_pkg::ABS_STRB_W-1:0] pstrb_i,
    output logic [abs_pkg::ABS_DATA_W-1:0]     prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    // Sequencer enable
    input  wire logic                          enable_input_i,
    // Destination and flags
    output logic [abs_pkg::ABS_DATA_W-1:0]     dest_o,
    output logic                               zero_flag_o,
    output logic                               borrow_flag_o,
    output logic                               carry_flag_o,
    output logic                               exec_o,
    // Interrupt
    output logic                               irq_o
);
    import abs_pkg::*;

    // ========================================================
    // Declarations
    logic                  rst_meta_r;
    logic                  rst_n;
    logic [ABS_CTRL_W-1:0] ctrl_r;
    logic [ABS_WORD_W-1:0] src1_lo_r;
    logic [ABS_WORD_W-1:0] src1_hi_r;
    logic [ABS_WORD_W-1:0] src2_lo_r;
    logic [ABS_WORD_W-1:0] src2_hi_r;
    logic [ABS_WORD_W-1:0] dest_lo_r;
    logic [ABS_WORD_W-1:0] dest_hi_r;
    abs_flags_t            flags_r;
    logic [ABS_IRQ_W-1:0]  irq_stat_r;
    logic [ABS_IRQ_W-1:0]  irq_stat_nxt;
    logic [ABS_IRQ_W-1:0]  irq_mask_r;
    logic [ABS_IRQ_W-1:0]  irq_event;
    logic [ABS_DATA_W-1:0] prdata_r;
    logic [ABS_DATA_W-1:0] rd_mux;
    logic                  slverr_r;
    logic                  addr_hit;
    logic                  setup_ph;
    logic                  wr_acc;
    logic [ABS_DATA_W-1:0] wmask;
    logic                  exec_r;
    logic                  fire;
    logic                  refuse;
    logic                  run;
    abs_req_t              req;
    abs_res_t              res;

    // ========================================================
    // Reset release through two flip-flops
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ========================================================
    // APB decode
    // Setup phase latches the read answer, access phase always completes
    assign setup_ph = psel_i & ~penable_i;
    assign wr_acc   = psel_i & penable_i & pwrite_i & addr_hit;
    assign pready_o = 1'b1;

    // Byte-lane write mask built from the strobes
    genvar gi;
    generate
        for (gi = 0; gi < ABS_STRB_W; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{pstrb_i[gi]}};
        end
    endgenerate

    // Address hit and read multiplexer
    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = ABS_DATA_ZERO;
        case (paddr_i)
            ABS_OFF_CTRL:     rd_mux[ABS_CTRL_W-1:0] = ctrl_r;
            ABS_OFF_SRC1_LO:  rd_mux[ABS_WORD_W-1:0] = src1_lo_r;
            ABS_OFF_SRC1_HI:  rd_mux[ABS_WORD_W-1:0] = src1_hi_r;
            ABS_OFF_SRC2_LO:  rd_mux[ABS_WORD_W-1:0] = src2_lo_r;
            ABS_OFF_SRC2_HI:  rd_mux[ABS_WORD_W-1:0] = src2_hi_r;
            ABS_OFF_DEST_LO:  rd_mux[ABS_WORD_W-1:0] = dest_lo_r;
            ABS_OFF_DEST_HI:  rd_mux[ABS_WORD_W-1:0] = dest_hi_r;
            ABS_OFF_FLAGS:    rd_mux[ABS_FLAG_W-1:0] = flags_r;
            ABS_OFF_IRQ_STAT: rd_mux[ABS_IRQ_W-1:0]  = irq_stat_r;
            ABS_OFF_IRQ_MASK: rd_mux[ABS_IRQ_W-1:0]  = irq_mask_r;
            default:          addr_hit = 1'b0;
        endcase
    end

    // Read data and error answer held from the setup phase
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= ABS_DATA_ZERO;
            slverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite_i ? ABS_DATA_ZERO : rd_mux;
            slverr_r <= ~addr_hit;
        end
    end

    assign prdata_o  = prdata_r;
    assign pslverr_o = slverr_r & psel_i & penable_i;

    // ========================================================
    // Control and mask registers
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r     <= ABS_CTRL_RST;
            irq_mask_r <= ABS_IRQ_RST;
        end else if (wr_acc) begin
            if (paddr_i == ABS_OFF_CTRL) begin
                ctrl_r <= (ctrl_r & ~wmask[ABS_CTRL_W-1:0]) | (pwdata_i[ABS_CTRL_W-1:0] & wmask[ABS_CTRL_W-1:0]);
            end
            if (paddr_i == ABS_OFF_IRQ_MASK) begin
                irq_mask_r <= (irq_mask_r & ~wmask[ABS_IRQ_W-1:0]) | (pwdata_i[ABS_IRQ_W-1:0] & wmask[ABS_IRQ_W-1:0]);
            end
        end
    end

    // ========================================================
    // Source operand words, low word first in each pair
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            src1_lo_r <= ABS_WORD_RST;
            src1_hi_r <= ABS_WORD_RST;
            src2_lo_r <= ABS_WORD_RST;
            src2_hi_r <= ABS_WORD_RST;
        end else if (wr_acc) begin
            case (paddr_i)
                ABS_OFF_SRC1_LO: begin
                    src1_lo_r <= (src1_lo_r & ~wmask[ABS_WORD_W-1:0]) | (pwdata_i[ABS_WORD_W-1:0] & wmask[ABS_WORD_W-1:0]);
                end
                ABS_OFF_SRC1_HI: begin
                    src1_hi_r <= (src1_hi_r & ~wmask[ABS_WORD_W-1:0]) | (pwdata_i[ABS_WORD_W-1:0] & wmask[ABS_WORD_W-1:0]);
                end
                ABS_OFF_SRC2_LO: begin
                    src2_lo_r <= (src2_lo_r & ~wmask[ABS_WORD_W-1:0]) | (pwdata_i[ABS_WORD_W-1:0] & wmask[ABS_WORD_W-1:0]);
                end
                ABS_OFF_SRC2_HI: begin
                    src2_hi_r <= (src2_hi_r & ~wmask[ABS_WORD_W-1:0]) | (pwdata_i[ABS_WORD_W-1:0] & wmask[ABS_WORD_W-1:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // Execution trigger from the sequencer enable
    abs_trig u_trig (
        .mclk_i         (mclk_i),
        .rst_n_i        (rst_n),
        .enable_input_i (enable_input_i),
        .pulse_mode_i   (ctrl_r[ABS_CTRL_PULSE]),
        .fire_o         (fire)
    );

    // Counter operands are refused by the 16-bit form
    assign refuse = fire & ctrl_r[ABS_CTRL_CTR] & ~ctrl_r[ABS_CTRL_WIDE];
    assign run    = fire & ~refuse;

    // Operand pairs assembled high word over low word
    assign req.sub  = ctrl_r[ABS_CTRL_SUB];
    assign req.wide = ctrl_r[ABS_CTRL_WIDE];
    assign req.src1 = {src1_hi_r, src1_lo_r};
    assign req.src2 = {src2_hi_r, src2_lo_r};

    abs_arith u_arith (
        .req_i (req),
        .res_o (res)
    );

    // ========================================================
    // Destination words; 16-bit form touches the low word only
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dest_lo_r <= ABS_WORD_RST;
            dest_hi_r <= ABS_WORD_RST;
        end else if (run) begin
            dest_lo_r <= res.dest[ABS_WORD_W-1:0];
            if (req.wide) begin
                dest_hi_r <= res.dest[ABS_DATA_W-1:ABS_WORD_W];
            end
        end
    end

    // ========================================================
    // Status flags, updated only when an operation runs
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= '0;
        end else if (run) begin
            flags_r.zero <= res.flags.zero;
            if (req.sub) begin
                flags_r.borrow <= res.flags.borrow;
            end else begin
                flags_r.carry <= res.flags.carry;
            end
        end
    end

    // Completion pulse one cycle after the operation
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            exec_r <= 1'b0;
        end else begin
            exec_r <= run;
        end
    end

    // ========================================================
    // Interrupt status: events set, write one clears, set wins
    always_comb begin
        irq_event                 = '0;
        irq_event[ABS_IRQ_DONE]   = run;
        irq_event[ABS_IRQ_CARRY]  = run & ~req.sub & res.flags.carry;
        irq_event[ABS_IRQ_BORROW] = run & req.sub & res.flags.borrow;
        irq_event[ABS_IRQ_ZERO]   = run & res.flags.zero;
        irq_event[ABS_IRQ_REFUSE] = refuse;
        irq_stat_nxt = irq_stat_r;
        if (wr_acc && (paddr_i == ABS_OFF_IRQ_STAT)) begin
            irq_stat_nxt = irq_stat_r & ~(pwdata_i[ABS_IRQ_W-1:0] & wmask[ABS_IRQ_W-1:0]);
        end
        irq_stat_nxt = irq_stat_nxt | irq_event;
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= ABS_IRQ_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign dest_o        = {dest_hi_r, dest_lo_r};
    assign zero_flag_o   = flags_r.zero;
    assign borrow_flag_o = flags_r.borrow;
    assign carry_flag_o  = flags_r.carry;
    assign exec_o        = exec_r;
    assign irq_o         = |(irq_stat_r & irq_mask_r);  // Level while any unmasked bit is set

endmodule // abs_top
`default_nettype wire

// ==== testbench/abs_top_monitor.sv ====
`default_nettype none
// ============================================================
// Port checker of the add/subtract unit
module abs_top_monitor
    import abs_pkg::*;
#(
    parameter int ADDR_W = ABS_ADDR_W
) (
    // Clock, reset and APB
    input wire logic                  mclk_i,
    input wire logic                  rstn_i,
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [ADDR_W-1:0]     paddr_i,
    input wire logic [ABS_DATA_W-1:0] pwdata_i,
    // Execution
    input wire logic                  enable_input_i,
    input wire logic [ABS_DATA_W-1:0] dest_o,
    input wire logic                  zero_flag_o,
    input wire logic                  borrow_flag_o,
    input wire logic                  carry_flag_o,
    input wire logic                  exec_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0]  ctrl_r;
    logic [31:0] s1_r, s2_r, a_w, b_w;
    logic [32:0] sum_w, exp_r;

    // Shadow of the control and source words
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= 4'h0;
            s1_r   <= 32'h0;
            s2_r   <= 32'h0;
        end else if (psel_i && penable_i && pwrite_i) begin
            case (paddr_i)
                ADDR_W'(ABS_OFF_CTRL):    ctrl_r <= pwdata_i[3:0];
                ADDR_W'(ABS_OFF_SRC1_LO): s1_r[15:0] <= pwdata_i[15:0];
                ADDR_W'(ABS_OFF_SRC1_HI): s1_r[31:16] <= pwdata_i[15:0];
                ADDR_W'(ABS_OFF_SRC2_LO): s2_r[15:0] <= pwdata_i[15:0];
                ADDR_W'(ABS_OFF_SRC2_HI): s2_r[31:16] <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // Expected sum or difference, width chosen by the control word
    always_comb begin
        a_w = ctrl_r[1] ? s1_r : {16'h0, s1_r[15:0]};
        b_w = ctrl_r[1] ? s2_r : {16'h0, s2_r[15:0]};
        sum_w = ctrl_r[0] ? {1'b0, a_w} - {1'b0, b_w} : {1'b0, a_w} + {1'b0, b_w};
    end

    // Expected value held for the cycle in which exec shows
    always_ff @(posedge mclk_i) begin
        exp_r <= {(ctrl_r[1] ? sum_w[32] : sum_w[16]), sum_w[31:0]};
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_pulse_held;
        ctrl_r[2] && enable_input_i ##1 enable_input_i;
    endsequence
    sequence s_refused;
        enable_input_i && ctrl_r[3] && !ctrl_r[1];
    endsequence

    a_idle_holds: assert property (!enable_input_i |=> $stable(dest_o) &&
        $stable({zero_flag_o, borrow_flag_o, carry_flag_o})) else $error("outputs moved while idle");
    a_pulse_once: assert property (s_pulse_held |=> !exec_o)
        else $error("pulse mode ran twice");
    a_refused_op: assert property (s_refused |=> !exec_o && $stable(dest_o))
        else $error("narrow counter op ran");
    a_dest_low: assert property (exec_o |-> dest_o[15:0] == exp_r[15:0])
        else $error("low result word wrong");
    a_dest_high: assert property (exec_o && ctrl_r[1] |-> dest_o[31:16] == exp_r[31:16])
        else $error("high result word wrong");
    a_high_kept: assert property (exec_o && !ctrl_r[1] |-> $stable(dest_o[31:16]))
        else $error("narrow op touched high word");
    a_zero_flag: assert property (exec_o |-> zero_flag_o ==
        (ctrl_r[1] ? dest_o == 32'h0 : dest_o[15:0] == 16'h0)) else $error("zero flag wrong");
    a_add_carry: assert property (exec_o && !ctrl_r[0] |-> carry_flag_o == exp_r[32] &&
        $stable(borrow_flag_o)) else $error("add flags wrong");
    a_sub_borrow: assert property (exec_o && ctrl_r[0] |-> borrow_flag_o == exp_r[32] &&
        $stable(carry_flag_o)) else $error("subtract flags wrong");
endmodule // abs_top_monitor

bind abs_top abs_top_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .enable_input_i(enable_input_i), .dest_o(dest_o), .zero_flag_o(zero_flag_o),
    .borrow_flag_o(borrow_flag_o), .carry_flag_o(carry_flag_o), .exec_o(exec_o));
`default_nettype wire

// ==== testbench/abs_seq_model.sv ====
`default_nettype none
// ============================================================
// Instruction sequencer model: drives the execution enable
module abs_seq_model (
    // Clock
    input  wire logic mclk_i,
    // Enable towards the unit
    output var logic  enable_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial enable_o = 1'b0;

    // Hold the enable for n edges, then idle for gap edges
    task automatic run(input int n, input int gap);
        enable_o <= 1'b1;
        repeat (n) @(posedge mclk_i);
        enable_o <= 1'b0;
        repeat (gap) @(posedge mclk_i);
    endtask
endmodule // abs_seq_model
`default_nettype wire

// ==== testbench/binary_add_sub_flags_tb.sv ====
`default_nettype none
// ============================================================
// Self-checking bench of the add/subtract unit
module binary_add_sub_flags_tb;
    import abs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, dest, e_dest = 32'h0;
    logic        pready, pslverr, en, zf, bf, cf, exec, irq;
    logic [2:0]  e_fl = 3'h0;
    logic [35:0] exp_q[$];
    logic [67:0] cases[12];
    int          errors = 0, n_compared = 0, cyc = 0;

    abs_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .enable_input_i(en), .dest_o(dest),
        .zero_flag_o(zf), .borrow_flag_o(bf), .carry_flag_o(cf), .exec_o(exec), .irq_o(irq));
    abs_seq_model u_seq (.mclk_i(mclk_i), .enable_o(en));

    // 40 MHz clock
    always #12.5 mclk_i = ~mclk_i;

    task automatic give_verdict();
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk($sformatf("reg %h", a), {3'h0, xe, x}, {3'h0, e, q});
    endtask

    // Load operands, note the expected results, then pulse the enable
    task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b, input int n);
        logic [32:0] s;
        wr(ABS_OFF_CTRL, {28'h0, c});
        wr(ABS_OFF_SRC1_LO, {16'h0, a[15:0]});
        wr(ABS_OFF_SRC1_HI, {16'h0, a[31:16]});
        wr(ABS_OFF_SRC2_LO, {16'h0, b[15:0]});
        wr(ABS_OFF_SRC2_HI, {16'h0, b[31:16]});
        if (!c[1]) begin
            a = {16'h0, a[15:0]};
            b = {16'h0, b[15:0]};
        end
        s = c[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        if (!(c[3] && !c[1])) begin
            e_dest = c[1] ? s[31:0] : {e_dest[31:16], s[15:0]};
            e_fl[2] = c[1] ? (s[31:0] == 32'h0) : (s[15:0] == 16'h0);
            e_fl[c[0] ? 1 : 0] = c[1] ? s[32] : s[16];
            repeat (c[2] ? 1 : n) exp_q.push_back({1'b0, e_dest, e_fl});
        end
        u_seq.run(n, 2);
    endtask

    // Each run shows as one exec cycle carrying the oldest noted result
    always @(posedge mclk_i) begin
        if (exec === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected run", 36'h0, 36'h1);
            else chk("result", exp_q.pop_front(), {1'b0, dest, zf, bf, cf});
        end
    end

    // Hang guard
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        cases = '{{4'h0, 32'h64, 32'hA}, {4'h0, 32'h7FFF, 32'h1}, {4'h0, 32'hFFFF, 32'h1},
                  {4'h0, 32'h1234FFFF, 32'hABCD0001}, {4'h2, 32'hA98AC7, 32'h2A62B1C},
                  {4'h2, 32'h80000000, 32'hFFFFFFFF}, {4'h1, 32'h64, 32'hA}, {4'h1, 32'h8000, 32'h1},
                  {4'h1, 32'h1, 32'h2}, {4'h1, 32'h0, 32'hFFFF}, {4'h3, 32'h80000000, 32'hFFFFFFFF},
                  {4'hA, 32'hFFFFFFFF, 32'h1}};
        void'($urandom(32'hECDC6928));
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        // Reset values, then an unmapped place
        for (int i = 0; i < 10; i++) rdc(8'(4 * i), 32'h0, 1'b0);
        rdc(8'h40, 32'h0, 1'b1);
        // Boundary cases of both widths and both operations
        for (int i = 0; i < 12; i++) op(cases[i][67:64], cases[i][63:32], cases[i][31:0], 1);
        repeat (20) op({2'b00, 2'($urandom)}, $urandom, $urandom, 1);
        op(4'h0, 32'h5, 32'h3, 3);
        op(4'h5, 32'h2, 32'h7, 4);
        op(4'h8, 32'h1, 32'h1, 2);
        // Read-only result and flag words
        wr(ABS_OFF_DEST_LO, 32'hFFFF);
        rdc(ABS_OFF_DEST_LO, {16'h0, e_dest[15:0]}, 1'b0);
        rdc(ABS_OFF_DEST_HI, {16'h0, e_dest[31:16]}, 1'b0);
        rdc(ABS_OFF_FLAGS, {29'h0, e_fl}, 1'b0);
        // Refusal event: masked, unmasked, then cleared
        chk("irq masked", 36'h0, {35'h0, irq});
        wr(ABS_OFF_IRQ_MASK, 32'h10);
        chk("irq raised", 36'h1, {35'h0, irq});
        wr(ABS_OFF_IRQ_STAT, 32'h10);
        chk("irq cleared", 36'h0, {35'h0, irq});
        chk("pending", 36'h0, 36'(exp_q.size()));
        give_verdict();
    end
endmodule // binary_add_sub_flags_tb
`default_nettype wire
